//--- shared/rpsd_pkg.sv
// rpsd_pkg: register map, field layout, lookup tables and types for the pattern step decoder
package rpsd_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_WORD_A = 8'h50;
  localparam logic [7:0] OFF_WORD_B = 8'h51;
  localparam logic [7:0] OFF_CTRL = 8'h52;
  localparam logic [7:0] OFF_STATUS = 8'h53;
  localparam logic [7:0] OFF_BLUE = 8'h54;
  localparam logic [7:0] OFF_RESET = 8'h60;
  localparam logic [7:0] WORD_RST = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_LOG_BIT = 0;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_FADE_BIT = 1;
  localparam int unsigned ST_DONE_BIT = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CLK_CYCLES_PER_MS = CLK_HZ / MS_PER_S;

  typedef logic [11:0] rpsd_ms_t;
  typedef logic [6:0] rpsd_pct_t;

  // step duration per 4-bit code, in ms
  localparam rpsd_ms_t STEP_MS [16] = '{12'd197, 12'd393, 12'd590, 12'd786, 12'd983, 12'd1180, 12'd1376,
    12'd1573, 12'd1769, 12'd1966, 12'd2163, 12'd2359, 12'd2556, 12'd2753, 12'd2949, 12'd3146};
  // fade time per 3-bit code, in ms; the last two extend the doubling series
  localparam rpsd_ms_t FADE_MS [8] = '{12'd0, 12'd55, 12'd110, 12'd221, 12'd442, 12'd885, 12'd1770, 12'd3540};
  // blue current in percent of maximum, linear and logarithmic scaling
  localparam rpsd_pct_t PCT_LIN [8] = '{7'd0, 7'd7, 7'd14, 7'd21, 7'd32, 7'd46, 7'd71, 7'd100};
  localparam rpsd_pct_t PCT_LOG [8] = '{7'd0, 7'd1, 7'd2, 7'd4, 7'd10, 7'd21, 7'd46, 7'd100};

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rpsd_bus_req_t;

  typedef struct packed {
    logic [3:0] dur_code;
    logic [2:0] blue_code;
    logic [2:0] fade_time_code;
  } rpsd_step_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FADE, ST_HOLD} rpsd_state_t;

endpackage : rpsd_pkg

//--- core/rpsd_level_decode.sv
// rpsd_level_decode: maps a 3-bit intensity code to percent of maximum current
`timescale 1ns/10ps
`default_nettype none
module rpsd_level_decode (
  // code in
  input wire logic [2:0] code,
  input wire logic log_sel,
  // level out
  output rpsd_pkg::rpsd_pct_t pct
);
  import rpsd_pkg::*;

  // both tables share the off and full-scale ends
  always_comb begin
    if (log_sel) begin
      pct = PCT_LOG[code];
    end else begin
      pct = PCT_LIN[code];
    end
  end

endmodule : rpsd_level_decode
`default_nettype wire

//--- core/rpsd_step_decode.sv
// rpsd_step_decode: pattern step word decode, blue fade/hold sequencer and soft reset register
// Function
// - duration code is word A bits 1-0 above word B bits 7-6, 197 to 3146 ms.
// - blue code is word B bits 5-3; linear codes 1-6 give 7,14,21,32,46,71 percent.
// - logarithmic codes 1-6 give 1,2,4,10,21,46 percent.
// - code 000 is off and code 111 is full current in both scalings.
// - fade code is word B bits 2-0; codes 0-5 give 0,55,110,221,442,885 ms.
// - any write to the reset register resets the whole device; nothing is stored.
`timescale 1ns/10ps
`default_nettype none
module rpsd_step_decode #(
  parameter int unsigned MS_CYCLES = rpsd_pkg::CLK_CYCLES_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire rpsd_pkg::rpsd_bus_req_t bus_req,
  output logic [7:0] rd_data_r,
  // device outputs
  output logic dev_reset_r,
  output rpsd_pkg::rpsd_pct_t blue_level_r,
  output logic step_busy_r
);
  import rpsd_pkg::*;

  localparam int unsigned PRE_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

  if (MS_CYCLES < 2) begin : g_chk
    $error("MS_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic soft_rst;
  logic start;
  logic [7:0] word_a_r;
  logic [7:0] word_b_r;
  logic log_r;
  logic done_r;
  rpsd_step_t step_r;
  rpsd_state_t state_r;
  rpsd_pct_t tgt_pct;
  rpsd_pct_t target_r;
  rpsd_ms_t dur_ms_r;
  rpsd_ms_t fade_ms_r;
  rpsd_ms_t ms_cnt_r;
  logic [PRE_W-1:0] pre_cnt_r;
  logic [12:0] acc_r;
  logic [12:0] acc_nxt;
  rpsd_pct_t diff_r;
  logic ms_tick;
  logic step_end;
  logic fade_step;

  // the reset register decodes the write alone, data is ignored
  assign soft_rst = bus_req.wr && (bus_req.addr == OFF_RESET);
  assign start = bus_req.wr && (bus_req.addr == OFF_CTRL) && bus_req.wdata[CTRL_START_BIT];
  assign ms_tick = (state_r != ST_IDLE) && (pre_cnt_r == PRE_W'(MS_CYCLES - 1));
  assign step_end = ms_tick && (ms_cnt_r == dur_ms_r - 12'd1);
  assign fade_step = (state_r == ST_FADE) && (blue_level_r != target_r) && ({1'b0, fade_ms_r} <= acc_r);

  // target level for the word as it now stands
  rpsd_level_decode u_blue_decode (
    .code(word_b_r[5:3]),
    .log_sel(log_r),
    .pct(tgt_pct)
  );

  // soft reset pulse, one cycle, also usable by the rest of the device
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dev_reset_r <= 1'b0;
    end else begin
      dev_reset_r <= soft_rst;
    end
  end

  // command words and scaling select
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_a_r <= WORD_RST;
      word_b_r <= WORD_RST;
      log_r <= 1'b0;
    end else if (soft_rst) begin
      word_a_r <= WORD_RST;
      word_b_r <= WORD_RST;
      log_r <= 1'b0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == OFF_WORD_A) begin
        word_a_r <= bus_req.wdata;
      end
      if (bus_req.addr == OFF_WORD_B) begin
        word_b_r <= bus_req.wdata;
      end
      if (bus_req.addr == OFF_CTRL) begin
        log_r <= bus_req.wdata[CTRL_LOG_BIT];
      end
    end
  end

  // latch the step on start so later word writes do not disturb a running step
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_r <= '0;
      target_r <= '0;
      dur_ms_r <= '0;
      fade_ms_r <= '0;
    end else if (soft_rst) begin
      step_r <= '0;
      target_r <= '0;
      dur_ms_r <= '0;
      fade_ms_r <= '0;
    end else if (start) begin
      step_r <= '{dur_code: {word_a_r[1:0], word_b_r[7:6]}, blue_code: word_b_r[5:3],
        fade_time_code: word_b_r[2:0]};
      target_r <= tgt_pct;
      dur_ms_r <= STEP_MS[{word_a_r[1:0], word_b_r[7:6]}];
      fade_ms_r <= FADE_MS[word_b_r[2:0]];
    end
  end

  // ----------------------------------------------------------------
  // step sequencer
  // ----------------------------------------------------------------
  // millisecond prescaler and elapsed time, restarted by each start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_r <= '0;
      ms_cnt_r <= '0;
    end else if (soft_rst || start || state_r == ST_IDLE) begin
      pre_cnt_r <= '0;
      ms_cnt_r <= '0;
    end else if (ms_tick) begin
      pre_cnt_r <= '0;
      ms_cnt_r <= ms_cnt_r + 12'd1;
    end else begin
      pre_cnt_r <= pre_cnt_r + PRE_W'(1);
    end
  end

  // state: a zero fade time goes straight to hold
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else if (soft_rst) begin
      state_r <= ST_IDLE;
    end else if (start) begin
      state_r <= (word_b_r[2:0] == 3'h0) ? ST_HOLD : ST_FADE;
    end else begin
      case (state_r)
        ST_IDLE: state_r <= ST_IDLE;
        ST_FADE: begin
          if (step_end) begin
            state_r <= ST_IDLE;
          end else if (blue_level_r == target_r) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (step_end) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // rate accumulator: adds the level span each ms, spends the fade time per one-percent move,
  // so the ramp covers the whole span in the fade time without a divider
  always_comb begin
    acc_nxt = acc_r;
    if (fade_step) begin
      acc_nxt = acc_nxt - {1'b0, fade_ms_r};
    end
    if (ms_tick && state_r == ST_FADE) begin
      acc_nxt = acc_nxt + {6'h00, diff_r};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= '0;
      diff_r <= '0;
    end else if (soft_rst) begin
      acc_r <= '0;
      diff_r <= '0;
    end else if (start) begin
      acc_r <= '0;
      diff_r <= (tgt_pct > blue_level_r) ? tgt_pct - blue_level_r : blue_level_r - tgt_pct;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // blue level: ramps, snaps to target if the step ends before the ramp does
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blue_level_r <= '0;
    end else if (soft_rst) begin
      blue_level_r <= '0;
    end else if (start && word_b_r[2:0] == 3'h0) begin
      blue_level_r <= tgt_pct;
    end else if (step_end) begin
      blue_level_r <= target_r;
    end else if (fade_step) begin
      blue_level_r <= (target_r > blue_level_r) ? blue_level_r + 7'd1 : blue_level_r - 7'd1;
    end
  end

  // busy flag and sticky done; a completion wins over a same-cycle clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (soft_rst) begin
      step_busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      step_busy_r <= start || (state_r != ST_IDLE && !step_end);
      if (step_end && !start) begin
        done_r <= 1'b1;
      end else if (bus_req.wr && bus_req.addr == OFF_STATUS && bus_req.wdata[ST_DONE_BIT]) begin
        done_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // data valid only in the cycle after the strobe; reset register reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        OFF_WORD_A: rd_data_r <= word_a_r;
        OFF_WORD_B: rd_data_r <= word_b_r;
        OFF_CTRL: rd_data_r <= {7'h00, log_r};
        OFF_STATUS: rd_data_r <= {5'h00, done_r, state_r == ST_FADE, state_r != ST_IDLE};
        OFF_BLUE: rd_data_r <= {1'b0, blue_level_r};
        default: rd_data_r <= 8'h00;
      endcase
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_dur_code_join: assert property (start |=> step_r.dur_code == {word_a_r[1:0], word_b_r[7:6]})
    else $error("duration code not joined from words A and B");
  a_dur_first_code: assert property (start && word_a_r[1:0] == 2'h0 && word_b_r[7:6] == 2'h0
    |=> dur_ms_r == 12'd197)
    else $error("duration code 0 not 197 ms");
  a_lin_level_32: assert property (start && !log_r && word_b_r[5:3] == 3'h4 |=> target_r == 7'd32)
    else $error("linear code 4 not 32 percent");
  a_log_level_21: assert property (start && log_r && word_b_r[5:3] == 3'h5 |=> target_r == 7'd21)
    else $error("log code 5 not 21 percent");
  a_end_levels: assert property (start && (word_b_r[5:3] == 3'h0 || word_b_r[5:3] == 3'h7)
    |=> target_r == ((step_r.blue_code == 3'h0) ? 7'd0 : 7'd100))
    else $error("off or full-scale level wrong");
  a_fade_time_885: assert property (start && word_b_r[2:0] == 3'h5 |=> fade_ms_r == 12'd885)
    else $error("fade code 5 not 885 ms");
  // back-to-back reset writes are legal, so the pulse only drops when no second write followed
  a_soft_reset_all: assert property (soft_rst |=> dev_reset_r && word_a_r == 8'h00 && word_b_r == 8'h00
    && state_r == ST_IDLE ##1 dev_reset_r == $past(soft_rst))
    else $error("reset register write did not reset the device");
  a_instant_fade: assert property (start && word_b_r[2:0] == 3'h0 |=> state_r == ST_HOLD
    && blue_level_r == target_r)
    else $error("zero fade time did not jump to level");
  // a zero-fade start lands in hold with a new level, so only a settled hold must keep it still
  a_hold_level: assert property (state_r == ST_HOLD |-> blue_level_r == target_r
    && ($stable(blue_level_r) || $past(start) || $past(state_r) != ST_HOLD))
    else $error("level moved during hold");

  c_fade_to_hold: cover property (state_r == ST_FADE ##1 state_r == ST_HOLD);
  c_step_done: cover property (state_r == ST_HOLD ##1 state_r == ST_IDLE);
  c_soft_reset: cover property (soft_rst);

endmodule : rpsd_step_decode
`default_nettype wire

//--- testbench/tb_top.sv
// tb_top: self-checking random bench for the pattern step decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rpsd_pkg::*;
  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  localparam int unsigned MC = 4; // ms shortened to 4 cycles to keep the run short
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  rpsd_bus_req_t bus_req = '0;
  logic [7:0] rd_data_r;
  logic dev_reset_r;
  rpsd_pct_t blue_level_r;
  logic step_busy_r;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] rd;
  int n;

  // clock at 40 MHz
  always #12.5 clk = ~clk;

  rpsd_step_decode #(.MS_CYCLES(MC)) DUT (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
    .rd_data_r(rd_data_r), .dev_reset_r(dev_reset_r), .blue_level_r(blue_level_r), .step_busy_r(step_busy_r));

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  function automatic logic [6:0] exp_pct(input logic [2:0] code, input logic lg);
    logic [6:0] lin [8];
    logic [6:0] lgt [8];
    lin = '{7'h00, 7'h07, 7'h0E, 7'h15, 7'h20, 7'h2E, 7'h47, 7'h64};
    lgt = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h0A, 7'h15, 7'h2E, 7'h64};
    return lg ? lgt[code] : lin[code];
  endfunction : exp_pct

  function automatic int exp_dur(input logic [3:0] code);
    logic [11:0] t [16];
    t = '{12'h0C5, 12'h189, 12'h24E, 12'h312, 12'h3D7, 12'h49C, 12'h560, 12'h625, 12'h6E9, 12'h7AE, 12'h873,
      12'h937, 12'h9FC, 12'hAC1, 12'hB85, 12'hC4A};
    return int'(t[code]);
  endfunction : exp_dur

  function automatic int exp_fade(input logic [2:0] code);
    logic [11:0] t [6];
    t = '{12'h000, 12'h037, 12'h06E, 12'h0DD, 12'h1BA, 12'h375};
    return int'(t[code]);
  endfunction : exp_fade

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // bounded counts are bench integers, so a range test is enough here
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : bw

  // read data is looked at in the one cycle where it stands
  task automatic br(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    d = rd_data_r;
  endtask : br

  task automatic step(input logic [7:0] a, input logic [7:0] b, input logic lg);
    bw(OFF_WORD_A, a);
    bw(OFF_WORD_B, b);
    bw(OFF_CTRL, {7'h00, lg});
    bw(OFF_CTRL, {6'h00, 1'b1, lg});
  endtask : step

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // watchdog: all tests need well under 70k cycles
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [3:0] dcode [3];
    void'($urandom(32'h14a68dd4));
    repeat (16) @(posedge clk);
    chk("level in reset", 16'h0000, {9'h000, blue_level_r});
    reset_n <= 1'b1;
    // pattern words read back; unmapped and reset addresses read zero
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom());
      bw(OFF_WORD_A + 8'(i & 1), d);
      br(OFF_WORD_A + 8'(i & 1), rd);
      chk("word readback", {8'h00, d}, {8'h00, rd});
    end
    bw(8'h7E, 8'hFF);
    br(8'h7E, rd);
    chk("unmapped read", 16'h0000, {8'h00, rd});
    br(OFF_RESET, rd);
    chk("reset reg read", 16'h0000, {8'h00, rd});
    // every blue code in both scalings, fade 0 lands at once
    for (int lg = 0; lg < 2; lg++) begin
      for (int c = 0; c < 8; c++) begin
        step({6'($urandom()), 2'b00}, {2'b00, 3'(c), 3'h0}, 1'(lg));
        @(negedge clk);
        chk("blue level", {9'h000, exp_pct(3'(c), 1'(lg))}, {9'h000, blue_level_r});
        br(OFF_BLUE, rd);
        chk("blue reg", {9'h000, exp_pct(3'(c), 1'(lg))}, {8'h00, rd});
      end
    end
    // step length, with the code split across the two words
    dcode = '{4'h0, 4'($urandom()), 4'hF};
    for (int i = 0; i < 3; i++) begin
      step({6'($urandom()), dcode[i][3:2]}, {dcode[i][1:0], 3'($urandom()), 3'h0}, 1'b0);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (step_busy_r === 1'b1 && n < 20000);
      chk_rng("step cycles", exp_dur(dcode[i]) * MC, exp_dur(dcode[i]) * MC + 2, n - 1);
      br(OFF_STATUS, rd);
      chk("done flag", 16'h0002, {14'h0000, rd[ST_DONE_BIT], rd[ST_BUSY_BIT]});
      // sticky done must drop on a write of one to its bit
      bw(OFF_STATUS, 8'(1 << ST_DONE_BIT));
      br(OFF_STATUS, rd);
      chk("done clear", 16'h0000, {15'h0000, rd[ST_DONE_BIT]});
    end
    // fade codes 1..5 ramp 0 to full after a soft reset, then hold
    for (int t = 1; t < 6; t++) begin
      bw(OFF_RESET, 8'($urandom()));
      @(negedge clk);
      chk("reset pulse", 16'h0001, {15'h0000, dev_reset_r});
      @(negedge clk);
      chk("reset pulse end", 16'h0000, {15'h0000, dev_reset_r});
      chk("level after reset", 16'h0000, {9'h000, blue_level_r});
      br(OFF_WORD_A, rd);
      chk("word after reset", {8'h00, WORD_RST}, {8'h00, rd});
      step(8'h01, {2'b00, 3'h7, 3'(t)}, 1'b0);
      n = 0;
      d = 8'h00;
      do begin
        @(negedge clk);
        n++;
        if (blue_level_r < d[6:0]) chk("ramp falls", {9'h000, d[6:0]}, {9'h000, blue_level_r});
        d = {1'b0, blue_level_r};
      end while (blue_level_r !== 7'h64 && n < 8000);
      chk_rng("fade cycles", exp_fade(3'(t)) * MC * 3 / 4, exp_fade(3'(t)) * MC + MC + 2, n);
      while (step_busy_r === 1'b1 && n < 8000) begin
        @(negedge clk);
        n++;
      end
      chk("held level", 16'h0064, {9'h000, blue_level_r});
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
